// >>> bsp_pkg.sv
// Shared constants and types for the stepper bridge phase control block.
// Assumes a single 125 MHz clock and an AXI4-Lite register master.
`default_nettype none

package bsp_pkg;

  // Clock and chopping oscillator timing
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int OSC_FREQ_KHZ = 1600;
  localparam logic [7:0] OSC_DIV_RESET = 8'(CLK_FREQ_KHZ / OSC_FREQ_KHZ);
  localparam logic [2:0] OVC_MASK_TICKS = 3'h4;

  // Register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_DRIVE = 4'h8;

  // Status field positions
  localparam int ST_THERMAL = 0;
  localparam int ST_OVC_A = 1;
  localparam int ST_OVC_B = 2;
  localparam int ST_MOTOR_OK = 3;
  localparam int ST_LOGIC_OK = 4;
  localparam int ST_HOLD = 5;
  localparam int ST_OSC_RUN = 6;

  // Drive register field positions
  localparam int DRV_A_LSB = 0;
  localparam int DRV_B_LSB = 8;

  // Synchroniser vector positions
  localparam int SYNC_W = 12;
  localparam int SI_A_EN1 = 0;
  localparam int SI_A_EN2 = 1;
  localparam int SI_A_DIR = 2;
  localparam int SI_B_EN1 = 3;
  localparam int SI_B_EN2 = 4;
  localparam int SI_B_DIR = 5;
  localparam int SI_HOLD = 6;
  localparam int SI_THERMAL = 7;
  localparam int SI_OVC_A = 8;
  localparam int SI_OVC_B = 9;
  localparam int SI_MOTOR_OK = 10;
  localparam int SI_LOGIC_OK = 11;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BSP_LVL_ZERO = 2'b00,
    BSP_LVL_LOW = 2'b01,
    BSP_LVL_MID = 2'b10,
    BSP_LVL_FULL = 2'b11
  } bsp_level_e;

  // One bridge: drive low means both legs high impedance
  typedef struct packed {
    logic drive;
    logic pos_high;
    logic neg_high;
    bsp_level_e level;
  } bsp_bridge_s;

  localparam bsp_bridge_s BRIDGE_OFF = '{1'b0, 1'b0, 1'b0, BSP_LVL_ZERO};

endpackage : bsp_pkg

`default_nettype wire

// >>> bsp_phase_ctrl.sv
// Two-channel bipolar stepper bridge phase control with AXI4-Lite status.
// Assumes host pins, trip and supply monitors feed in; one clock, sync reset.
// Notes on behaviour
// - With both enables of a channel low its bridge is high impedance, direction ignored.
// - An enabled channel drives the positive leg high when direction is high, else the negative.
// - Hold input low stops the chopping oscillator and all bridge drivers.
// - A thermal trip switches both bridge outputs off and latches that state.
// - The thermal latch clears only on power-on reset or a high-low-high of the hold input.
// - While either supply monitor reports undervoltage both bridge outputs are forced off.
// - A channel overcurrent trip switches off only that channel and latches.
// - An overcurrent latch clears only on power-on reset or a high-low-high of the hold input.
// - Overcurrent shorter than four oscillator cycles is ignored as noise.
// - While any overcurrent latch is set the chopping oscillator is stopped.
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module bsp_phase_ctrl (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic CHAN_A_ENABLE_ONE,
  input wire logic CHAN_A_ENABLE_TWO,
  input wire logic CHAN_A_DIRECTION,
  input wire logic CHAN_B_ENABLE_ONE,
  input wire logic CHAN_B_ENABLE_TWO,
  input wire logic CHAN_B_DIRECTION,
  input wire logic HOLD_RELEASE,
  input wire logic THERMAL_TRIP,
  input wire logic [1:0] OVERCURRENT_TRIP,
  input wire logic MOTOR_SUPPLY_OK,
  input wire logic LOGIC_SUPPLY_OK,
  output var bsp_pkg::bsp_bridge_s BRIDGE_A,
  output var bsp_pkg::bsp_bridge_s BRIDGE_B,
  output logic CHOP_OSCILLATOR_TICK,
  input wire logic [bsp_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [bsp_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import bsp_pkg::*;

  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;
  logic [7:0] osc_div;
  logic [7:0] osc_cnt;
  logic osc_run;
  logic osc_tick;
  logic therm_latch;
  logic [1:0] ovc_latch;
  logic [2:0] ovc_cnt [2];
  logic hold_s;
  logic supply_ok;
  logic [1:0] en1_s;
  logic [1:0] en2_s;
  logic [1:0] dir_s;
  logic [1:0] ovc_s;
  bsp_bridge_s bridge_q [2];
  logic wr_fire;
  logic rd_fire;
  logic [31:0] status_word;
  logic [31:0] drive_word;

  assign raw_in = {LOGIC_SUPPLY_OK, MOTOR_SUPPLY_OK, OVERCURRENT_TRIP, THERMAL_TRIP,
                   HOLD_RELEASE, CHAN_B_DIRECTION, CHAN_B_ENABLE_TWO, CHAN_B_ENABLE_ONE,
                   CHAN_A_DIRECTION, CHAN_A_ENABLE_TWO, CHAN_A_ENABLE_ONE};

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      sync_meta <= '0;
      sync_q <= '0;
    end else begin
      sync_meta <= raw_in;
      sync_q <= sync_meta;
    end
  end

  assign hold_s = sync_q[SI_HOLD];
  assign supply_ok = sync_q[SI_MOTOR_OK] & sync_q[SI_LOGIC_OK];
  assign en1_s = {sync_q[SI_B_EN1], sync_q[SI_A_EN1]};
  assign en2_s = {sync_q[SI_B_EN2], sync_q[SI_A_EN2]};
  assign dir_s = {sync_q[SI_B_DIR], sync_q[SI_A_DIR]};
  assign ovc_s = {sync_q[SI_OVC_B], sync_q[SI_OVC_A]};

  // Chopping oscillator as a gated enable pulse
  assign osc_run = hold_s & ~|ovc_latch;
  assign osc_tick = osc_run && (osc_cnt >= osc_div - 8'h01);
  assign CHOP_OSCILLATOR_TICK = osc_tick;

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      osc_cnt <= 8'h00;
    end else if (!osc_run || osc_tick) begin
      osc_cnt <= 8'h00;
    end else begin
      osc_cnt <= osc_cnt + 8'h01;
    end
  end

  // Thermal latch; a trip in the clearing cycle wins
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      therm_latch <= 1'b0;
    end else if (sync_q[SI_THERMAL]) begin
      therm_latch <= 1'b1;
    end else if (!hold_s) begin
      therm_latch <= 1'b0;
    end
  end

  // Per-channel overcurrent mask counter, latch and bridge decode
  for (genvar c = 0; c < 2; c++) begin : g_chan
    always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
        ovc_cnt[c] <= 3'h0;
      end else if (!ovc_s[c] || !hold_s) begin
        ovc_cnt[c] <= 3'h0;
      end else if (osc_tick && ovc_cnt[c] < OVC_MASK_TICKS) begin
        ovc_cnt[c] <= ovc_cnt[c] + 3'h1;
      end
    end

    always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
        ovc_latch[c] <= 1'b0;
      end else if (ovc_s[c] && ovc_cnt[c] == OVC_MASK_TICKS) begin
        ovc_latch[c] <= 1'b1;
      end else if (!hold_s) begin
        ovc_latch[c] <= 1'b0;
      end
    end

    always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
        bridge_q[c] <= BRIDGE_OFF;
      end else if (!hold_s || therm_latch || !supply_ok || ovc_latch[c]) begin
        bridge_q[c] <= BRIDGE_OFF;
      end else if (!en1_s[c] && !en2_s[c]) begin
        bridge_q[c] <= BRIDGE_OFF;
      end else begin
        bridge_q[c].drive <= 1'b1;
        bridge_q[c].pos_high <= dir_s[c];
        bridge_q[c].neg_high <= ~dir_s[c];
        bridge_q[c].level <= bsp_level_e'({en1_s[c], en2_s[c]});
      end
    end
  end

  assign BRIDGE_A = bridge_q[0];
  assign BRIDGE_B = bridge_q[1];

  // Register views
  always_comb begin
    status_word = '0;
    status_word[ST_THERMAL] = therm_latch;
    status_word[ST_OVC_A] = ovc_latch[0];
    status_word[ST_OVC_B] = ovc_latch[1];
    status_word[ST_MOTOR_OK] = sync_q[SI_MOTOR_OK];
    status_word[ST_LOGIC_OK] = sync_q[SI_LOGIC_OK];
    status_word[ST_HOLD] = hold_s;
    status_word[ST_OSC_RUN] = osc_run;
    drive_word = '0;
    drive_word[DRV_A_LSB +: $bits(bsp_bridge_s)] = bridge_q[0];
    drive_word[DRV_B_LSB +: $bits(bsp_bridge_s)] = bridge_q[1];
  end

  // AXI4-Lite write: address and data taken together
  assign wr_fire = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
  assign S_AXI_AWREADY = wr_fire;
  assign S_AXI_WREADY = wr_fire;

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      if (S_AXI_AWADDR == REG_CTRL || S_AXI_AWADDR == REG_STATUS ||
          S_AXI_AWADDR == REG_DRIVE) begin
        S_AXI_BRESP <= RESP_OKAY;
      end else begin
        S_AXI_BRESP <= RESP_SLVERR;
      end
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Oscillator divider, zero is held off as one
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      osc_div <= OSC_DIV_RESET;
    end else if (wr_fire && S_AXI_AWADDR == REG_CTRL && S_AXI_WSTRB[0]) begin
      if (S_AXI_WDATA[7:0] == 8'h00) begin
        osc_div <= 8'h01;
      end else begin
        osc_div <= S_AXI_WDATA[7:0];
      end
    end
  end

  // AXI4-Lite read
  assign rd_fire = S_AXI_ARVALID && !S_AXI_RVALID;
  assign S_AXI_ARREADY = rd_fire;

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (rd_fire) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= RESP_OKAY;
      if (S_AXI_ARADDR == REG_CTRL) begin
        S_AXI_RDATA <= {24'h00_0000, osc_div};
      end else if (S_AXI_ARADDR == REG_STATUS) begin
        S_AXI_RDATA <= status_word;
      end else if (S_AXI_ARADDR == REG_DRIVE) begin
        S_AXI_RDATA <= drive_word;
      end else begin
        S_AXI_RDATA <= 32'h0000_0000;
        S_AXI_RRESP <= RESP_SLVERR;
      end
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  a_sync_two_stage: assert property (RESET_N && $past(RESET_N) && $past(RESET_N, 2) |->
    sync_q == $past(raw_in, 2)) else $error("Synchroniser delay is not two cycles");

  a_idle_hiz: assert property (!en1_s[0] && !en2_s[0] |=>
    !BRIDGE_A.drive && !BRIDGE_A.pos_high && !BRIDGE_A.neg_high)
    else $error("Channel A drives with both enables low");

  a_idle_hiz_b: assert property (!en1_s[1] && !en2_s[1] |=>
    !BRIDGE_B.drive && !BRIDGE_B.pos_high && !BRIDGE_B.neg_high)
    else $error("Channel B drives with both enables low");

  a_dir_legs: assert property (BRIDGE_B.drive |->
    BRIDGE_B.pos_high == $past(dir_s[1]) && BRIDGE_B.neg_high == !$past(dir_s[1]))
    else $error("Channel B legs do not follow direction");

  a_hold_off: assert property (!hold_s |-> !CHOP_OSCILLATOR_TICK ##1
    !BRIDGE_A.drive && !BRIDGE_B.drive)
    else $error("Drive or oscillator active in hold");

  a_therm_off: assert property (sync_q[SI_THERMAL] |=>
    therm_latch ##1 !BRIDGE_A.drive && !BRIDGE_B.drive)
    else $error("Thermal trip did not latch outputs off");

  a_therm_keep: assert property (therm_latch && hold_s |=> therm_latch)
    else $error("Thermal latch cleared without hold sequence");

  a_therm_clear: assert property (!hold_s && !sync_q[SI_THERMAL] |=> !therm_latch)
    else $error("Thermal latch not cleared during hold");

  a_supply_off: assert property (!supply_ok |=> !BRIDGE_A.drive && !BRIDGE_B.drive)
    else $error("Outputs driven under undervoltage");

  a_ovc_chan: assert property (ovc_latch[0] |=> !BRIDGE_A.drive)
    else $error("Channel A drives while its overcurrent latch is set");

  a_ovc_chan_b: assert property (ovc_latch[1] |=> !BRIDGE_B.drive)
    else $error("Channel B drives while its overcurrent latch is set");

  a_ovc_keep: assert property (ovc_latch[1] && hold_s |=> ovc_latch[1])
    else $error("Overcurrent latch cleared without hold sequence");

  a_ovc_clear: assert property (!hold_s && !ovc_s[0] |=> !ovc_latch[0])
    else $error("Overcurrent latch not cleared during hold");

  a_ovc_mask: assert property ($rose(ovc_latch[0]) |->
    $past(ovc_s[0]) && $past(ovc_cnt[0]) == OVC_MASK_TICKS)
    else $error("Overcurrent latched before mask time");

  a_osc_stop: assert property (|ovc_latch |-> !CHOP_OSCILLATOR_TICK)
    else $error("Oscillator runs during overcurrent shutdown");

  a_level_map: assert property (BRIDGE_A.drive |->
    BRIDGE_A.level == bsp_level_e'({$past(en1_s[0]), $past(en2_s[0])}))
    else $error("Channel A level does not match enables");

endmodule : bsp_phase_ctrl

`default_nettype wire

// >>> bsp_host_model.sv
// Host controller model driving the enable, direction and hold pins.
// Assumes the bench posts requests; pins move just after a clock edge.
`timescale 1ns/10ps
`default_nettype none

module bsp_host_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] en_a_req,
  input wire logic dir_a_req,
  input wire logic [1:0] en_b_req,
  input wire logic dir_b_req,
  input wire logic hold_req,
  output logic [2:0] pins_a,
  output logic [2:0] pins_b,
  output logic hold_pin
);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pins_a <= 3'h0;
      pins_b <= 3'h0;
      hold_pin <= 1'b0;
    end else begin
      pins_a <= {en_a_req, dir_a_req};
      pins_b <= {en_b_req, dir_b_req};
      hold_pin <= hold_req;
    end
  end
endmodule : bsp_host_model

`default_nettype wire

// >>> bsp_phase_ctrl_bench.sv
// Self-checking bench for the stepper bridge phase control block.
// Assumes the host model on the pins and an AXI4-Lite master task set.
`timescale 1ns/10ps
`default_nettype none

module bsp_phase_ctrl_bench;
  import bsp_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] en_a = 2'h0;
  logic [1:0] en_b = 2'h0;
  logic dir_a = 1'b0;
  logic dir_b = 1'b0;
  logic hold = 1'b0;
  logic thermal = 1'b0;
  logic [1:0] ovc = 2'h0;
  logic [1:0] sup_ok = 2'h3;
  logic [2:0] pins_a;
  logic [2:0] pins_b;
  logic hold_pin;
  bsp_bridge_s br_a;
  bsp_bridge_s br_b;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [1:0] rsp;
  int num_errors = 0;
  int n_tests = 0;
  int ticks = 0;
  logic tick;

  always #4 ref_clk = ~ref_clk;

  bsp_host_model i_bsp_host_model (.clk(ref_clk), .reset_n(reset_n), .en_a_req(en_a),
    .dir_a_req(dir_a), .en_b_req(en_b), .dir_b_req(dir_b), .hold_req(hold),
    .pins_a(pins_a), .pins_b(pins_b), .hold_pin(hold_pin));

  bsp_phase_ctrl i_bsp_phase_ctrl (.REF_CLK(ref_clk), .RESET_N(reset_n),
    .CHAN_A_ENABLE_ONE(pins_a[2]), .CHAN_A_ENABLE_TWO(pins_a[1]), .CHAN_A_DIRECTION(pins_a[0]),
    .CHAN_B_ENABLE_ONE(pins_b[2]), .CHAN_B_ENABLE_TWO(pins_b[1]), .CHAN_B_DIRECTION(pins_b[0]),
    .HOLD_RELEASE(hold_pin), .THERMAL_TRIP(thermal), .OVERCURRENT_TRIP(ovc),
    .MOTOR_SUPPLY_OK(sup_ok[1]), .LOGIC_SUPPLY_OK(sup_ok[0]), .BRIDGE_A(br_a),
    .BRIDGE_B(br_b), .CHOP_OSCILLATOR_TICK(tick), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : chk

  task wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_cyc

  task count_ticks(input int n);
    ticks = 0;
    repeat (n) begin
      @(posedge ref_clk);
      if (tick !== 1'b0) begin
        ticks++;
      end
    end
  endtask : count_ticks

  task timed_out(input int n);
    if (n >= 50) begin
      $display("unexpected bus_wait: expected answer seen none");
      num_errors++;
      wrap_up();
    end
  endtask : timed_out

  task axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge ref_clk); while (!(awready && wready) && ++n < 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge ref_clk); while (!bvalid && ++n < 50);
    timed_out(n);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask : axi_wr

  task axi_rd(input logic [3:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (!arready && ++n < 50);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid && ++n < 50);
    timed_out(n);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask : axi_rd

  function automatic bsp_bridge_s exp_br(input logic [1:0] en, input logic dir);
    exp_br = (en == 2'h0) ? BRIDGE_OFF : bsp_bridge_s'{1'b1, dir, !dir, bsp_level_e'(en)};
  endfunction : exp_br

  task chk_br(input bsp_bridge_s ea, input bsp_bridge_s eb);
    chk("bridge_a", {27'h0, ea}, {27'h0, br_a});
    chk("bridge_b", {27'h0, eb}, {27'h0, br_b});
  endtask : chk_br

  task set_pins(input logic [1:0] ea, input logic da, input logic [1:0] eb, input logic db);
    en_a <= ea;
    dir_a <= da;
    en_b <= eb;
    dir_b <= db;
    wait_cyc(320);
  endtask : set_pins

  task hold_pulse;
    hold <= 1'b0;
    wait_cyc(6);
    hold <= 1'b1;
    wait_cyc(40);
  endtask : hold_pulse

  initial begin
    wait_cyc(5);
    reset_n <= 1'b1;
    hold <= 1'b1;
    wait_cyc(6);
    chk_br(BRIDGE_OFF, BRIDGE_OFF);
    axi_rd(REG_CTRL);
    chk("ctrl_reset", 32'h0000004E, rd);
    axi_rd(4'hC);
    chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped_data", 32'h0, rd);
    axi_wr(REG_STATUS, 32'hFF);
    chk("status_wr_resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    axi_rd(REG_STATUS);
    chk("status_idle", 32'h00000078, rd);
    axi_wr(4'hC, 32'h00000001);
    chk("unmapped_wr_resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    axi_wr(REG_CTRL, 32'h00000000);
    axi_rd(REG_CTRL);
    chk("ctrl_zero", 32'h00000001, rd);
    axi_wr(REG_CTRL, 32'h8);
    axi_rd(REG_CTRL);
    chk("ctrl_write", 32'h8, rd);
    count_ticks(80);
    chk("tick_count", 32'h0000000A, ticks);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      set_pins(i[2:1], i[0], ~i[2:1], !i[0]);
      chk_br(exp_br(i[2:1], i[0]), exp_br(~i[2:1], !i[0]));
    end
    axi_rd(REG_DRIVE);
    chk("drive_reg", {19'h0, BRIDGE_OFF, 3'h0, exp_br(2'h3, 1'b1)}, rd);
    $display("test decode done");
    set_pins(2'h3, 1'b1, 2'h2, 1'b0);
    hold <= 1'b0;
    wait_cyc(6);
    chk_br(BRIDGE_OFF, BRIDGE_OFF);
    axi_rd(REG_STATUS);
    chk("status_hold", 32'h00000018, rd);
    hold <= 1'b1;
    wait_cyc(40);
    chk_br(exp_br(2'h3, 1'b1), exp_br(2'h2, 1'b0));
    for (int k = 0; k < 2; k++) begin
      sup_ok <= k ? 2'h1 : 2'h2;
      wait_cyc(6);
      chk_br(BRIDGE_OFF, BRIDGE_OFF);
      sup_ok <= 2'h3;
      wait_cyc(40);
      chk_br(exp_br(2'h3, 1'b1), exp_br(2'h2, 1'b0));
    end
    $display("test hold and supply done");
    thermal <= 1'b1;
    wait_cyc(4);
    thermal <= 1'b0;
    wait_cyc(20);
    chk_br(BRIDGE_OFF, BRIDGE_OFF);
    axi_rd(REG_STATUS);
    chk("thermal_latch", 32'h1, rd & 32'h1);
    hold_pulse();
    chk_br(exp_br(2'h3, 1'b1), exp_br(2'h2, 1'b0));
    $display("test thermal done");
    ovc <= 2'h1;
    wait_cyc(10);
    ovc <= 2'h0;
    wait_cyc(60);
    chk_br(exp_br(2'h3, 1'b1), exp_br(2'h2, 1'b0));
    for (int c = 0; c < 2; c++) begin
      ovc <= c ? 2'h2 : 2'h1;
      wait_cyc(80);
      chk_br(c ? exp_br(2'h3, 1'b1) : BRIDGE_OFF, c ? BRIDGE_OFF : exp_br(2'h2, 1'b0));
      count_ticks(16);
      chk("tick_stop", 32'h0, ticks);
      axi_rd(REG_STATUS);
      chk("status_ovc", c ? 32'h3C : 32'h3A, rd);
      ovc <= 2'h0;
      wait_cyc(40);
      chk_br(c ? exp_br(2'h3, 1'b1) : BRIDGE_OFF, c ? BRIDGE_OFF : exp_br(2'h2, 1'b0));
      hold_pulse();
      chk_br(exp_br(2'h3, 1'b1), exp_br(2'h2, 1'b0));
    end
    $display("test overcurrent done");
    thermal <= 1'b1;
    wait_cyc(4);
    thermal <= 1'b0;
    wait_cyc(2);
    chk_br(BRIDGE_OFF, BRIDGE_OFF);
    reset_n <= 1'b0;
    wait_cyc(5);
    reset_n <= 1'b1;
    wait_cyc(40);
    chk_br(exp_br(2'h3, 1'b1), exp_br(2'h2, 1'b0));
    axi_rd(REG_STATUS);
    chk("status_reboot", 32'h00000078, rd);
    axi_rd(REG_CTRL);
    chk("ctrl_reboot", 32'h0000004E, rd);
    $display("test reboot done");
    wrap_up();
  end
endmodule : bsp_phase_ctrl_bench

`default_nettype wire
